// ### logic/eal_alu.v
// execution unit: byte, word and multiply arithmetic with flag update
`timescale 1ns/100ps
`default_nettype none
`include "eal_map.vh"

module eal_alu #(
	parameter IMM_W = 6
) (
	input  wire             clock,
	input  wire             reset,
	input  wire             start,
	input  wire [4:0]       opSel,
	input  wire [7:0]       opA,
	input  wire [7:0]       opB,
	input  wire [15:0]      wordIn,
	input  wire [IMM_W-1:0] wordImm,
	input  wire [7:0]       flagsIn,
	output reg  [7:0]       resultLo_r,
	output reg  [7:0]       resultHi_r,
	output reg              wrByte_r,
	output reg              wrPair_r,
	output reg              wrProd_r,
	output reg  [7:0]       flagsOut_r,
	output reg  [7:0]       flagMask_r,
	output reg              done_r,
	output reg              busy_r
);

	// =========================================
	// helpers

	// returns {carry or borrow, half carry or borrow, result}
	function [9:0] addSub;
		input [7:0] x;
		input [7:0] y;
		input       ci;
		input       sub;
		reg   [8:0] t;
		reg   [4:0] l;
		begin
			if (sub) begin
				t = {1'b0, x} - {1'b0, y} - {8'h00, ci};
				l = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
			end else begin
				t = {1'b0, x} + {1'b0, y} + {8'h00, ci};
				l = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
			end
			addSub = {t[8], l[4], t[7:0]};
		end
	endfunction

	// two's complement overflow of an 8-bit add or subtract
	function ovf;
		input [7:0] x;
		input [7:0] y;
		input [7:0] r;
		input       sub;
		begin
			if (sub)
				ovf = (x[7] != y[7]) && (r[7] != x[7]);
			else
				ovf = (x[7] == y[7]) && (r[7] != x[7]);
		end
	endfunction

	// 16x16 product, low half kept
	function [15:0] mul16;
		input [15:0] x;
		input [15:0] y;
		reg   [31:0] p;
		begin
			p = x * y;
			mul16 = p[15:0];
		end
	endfunction

	// =========================================
	// two-cycle operand hold

	reg  [4:0]       op_r;
	reg  [7:0]       a_r;
	reg  [7:0]       b_r;
	reg  [15:0]      w_r;
	reg  [IMM_W-1:0] k_r;
	reg  [7:0]       f_r;

	wire             longOp;
	wire             commit;
	wire [4:0]       curOp;
	wire [7:0]       a;
	wire [7:0]       b;
	wire [15:0]      w;
	wire [15:0]      k;
	wire [7:0]       f;

	// word ops and multiplies hold their operands for a second cycle
	assign longOp = (opSel == `EAL_OP_WADD) || (opSel == `EAL_OP_WSUB) ||
		(opSel == `EAL_OP_MULU) || (opSel == `EAL_OP_PRDS) ||
		(opSel == `EAL_OP_PRDSU) || (opSel == `EAL_OP_FMULU) ||
		(opSel == `EAL_OP_FPRDS);
	// start is ignored while busy, no queueing
	assign commit = busy_r | (start & ~longOp);
	assign curOp  = busy_r ? op_r : opSel;
	assign a      = busy_r ? a_r : opA;
	assign b      = busy_r ? b_r : opB;
	assign w      = busy_r ? w_r : wordIn;
	assign k      = {{(16-IMM_W){1'b0}}, (busy_r ? k_r : wordImm)};
	assign f      = busy_r ? f_r : flagsIn;

	// =========================================
	// datapath

	reg  [9:0]  as;
	reg  [7:0]  r8;
	reg  [15:0] r16;
	reg  [15:0] prod;
	reg         wide;
	reg         cF;
	reg         hF;
	reg         vF;
	reg         zF;
	reg         nF;
	reg         zKeep;
	reg  [7:0]  msk;
	reg  [7:0]  nfl;
	reg         wB;
	reg         wP;
	reg         wM;

	always @* begin
		as    = 10'h000;
		r8    = `EAL_ALL_ZERO;
		r16   = 16'h0000;
		prod  = 16'h0000;
		wide  = 1'b0;
		cF    = 1'b0;
		hF    = 1'b0;
		vF    = 1'b0;
		zKeep = 1'b1;
		msk   = `EAL_MSK_NONE;
		wB    = 1'b0;
		wP    = 1'b0;
		wM    = 1'b0;
		case (curOp)
			`EAL_OP_ADD, `EAL_OP_ADC: begin
				as  = addSub(a, b, (curOp == `EAL_OP_ADC) & f[`EAL_FLG_C], 1'b0);
				r8  = as[7:0];
				cF  = as[9];
				hF  = as[8];
				vF  = ovf(a, b, r8, 1'b0);
				msk = `EAL_MSK_ARITH;
				wB  = 1'b1;
			end
			`EAL_OP_SUB: begin
				as  = addSub(a, b, 1'b0, 1'b1);
				r8  = as[7:0];
				cF  = as[9];
				hF  = as[8];
				vF  = ovf(a, b, r8, 1'b1);
				msk = `EAL_MSK_ARITH;
				wB  = 1'b1;
			end
			`EAL_OP_SBB: begin
				as    = addSub(a, b, f[`EAL_FLG_C], 1'b1);
				r8    = as[7:0];
				cF    = as[9];
				hF    = as[8];
				vF    = ovf(a, b, r8, 1'b1);
				// zero only survives a chain of zero bytes
				zKeep = f[`EAL_FLG_Z];
				msk   = `EAL_MSK_ARITH;
				wB    = 1'b1;
			end
			`EAL_OP_AND: begin
				r8  = a & b;
				msk = `EAL_MSK_LOGIC;
				wB  = 1'b1;
			end
			`EAL_OP_OR, `EAL_OP_XOR: begin
				r8  = (curOp == `EAL_OP_OR) ? (a | b) : (a ^ b);
				msk = `EAL_MSK_LOGIC;
				wB  = 1'b1;
			end
			`EAL_OP_INV: begin
				r8  = `EAL_ALL_ONES - a;
				cF  = 1'b1;
				msk = `EAL_MSK_INV;
				wB  = 1'b1;
			end
			`EAL_OP_NEGT: begin
				as  = addSub(`EAL_ALL_ZERO, a, 1'b0, 1'b1);
				r8  = as[7:0];
				cF  = as[9];
				hF  = as[8];
				vF  = ovf(`EAL_ALL_ZERO, a, r8, 1'b1);
				msk = `EAL_MSK_ARITH;
				wB  = 1'b1;
			end
			`EAL_OP_SETM, `EAL_OP_CLRM: begin
				r8  = (curOp == `EAL_OP_SETM) ? (a | b) : (a & (`EAL_ALL_ONES - b));
				msk = `EAL_MSK_LOGIC;
				wB  = 1'b1;
			end
			`EAL_OP_FILL: begin
				r8  = `EAL_ALL_ONES;
				wB  = 1'b1;
			end
			`EAL_OP_INC, `EAL_OP_DECR: begin
				as  = addSub(a, 8'h01, 1'b0, curOp == `EAL_OP_DECR);
				r8  = as[7:0];
				vF  = ovf(a, 8'h01, r8, curOp == `EAL_OP_DECR);
				msk = `EAL_MSK_LOGIC;
				wB  = 1'b1;
			end
			`EAL_OP_TSTV, `EAL_OP_ZERO: begin
				r8  = (curOp == `EAL_OP_TSTV) ? (a & a) : (a ^ a);
				msk = `EAL_MSK_LOGIC;
				wB  = 1'b1;
			end
			`EAL_OP_WADD: begin
				r16  = w + k;
				wide = 1'b1;
				vF   = ~w[15] & r16[15];
				cF   = w[15] & ~r16[15];
				msk  = `EAL_MSK_WORD;
				wP   = 1'b1;
			end
			`EAL_OP_WSUB: begin
				r16  = w - k;
				wide = 1'b1;
				vF   = w[15] & ~r16[15];
				cF   = r16[15] & ~w[15];
				msk  = `EAL_MSK_WORD;
				wP   = 1'b1;
			end
			`EAL_OP_MULU, `EAL_OP_FMULU: begin
				prod = mul16({8'h00, a}, {8'h00, b});
				wide = 1'b1;
				cF   = prod[15];
				// fractional form drops the doubled sign bit
				r16  = (curOp == `EAL_OP_FMULU) ? {prod[14:0], 1'b0} : prod;
				msk  = `EAL_MSK_PROD;
				wM   = 1'b1;
			end
			`EAL_OP_PRDS, `EAL_OP_FPRDS: begin
				prod = mul16({{8{a[7]}}, a}, {{8{b[7]}}, b});
				wide = 1'b1;
				cF   = prod[15];
				r16  = (curOp == `EAL_OP_FPRDS) ? {prod[14:0], 1'b0} : prod;
				msk  = `EAL_MSK_PROD;
				wM   = 1'b1;
			end
			`EAL_OP_PRDSU: begin
				prod = mul16({{8{a[7]}}, a}, {8'h00, b});
				wide = 1'b1;
				cF   = prod[15];
				r16  = prod;
				msk  = `EAL_MSK_PROD;
				wM   = 1'b1;
			end
			default: begin
				msk = `EAL_MSK_NONE;
			end
		endcase
		if (!wide)
			r16 = {8'h00, r8};
		zF = zKeep & (wide ? (r16 == 16'h0000) : (r8 == `EAL_ALL_ZERO));
		nF = wide ? r16[15] : r8[7];
		nfl = 8'h00;
		nfl[`EAL_FLG_C] = cF;
		nfl[`EAL_FLG_Z] = zF;
		nfl[`EAL_FLG_N] = nF;
		nfl[`EAL_FLG_V] = vF;
		nfl[`EAL_FLG_S] = nF ^ vF;
		nfl[`EAL_FLG_H] = hF;
	end

	// =========================================
	// sequencing and output registers

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			op_r       <= 5'h00;
			a_r        <= 8'h00;
			b_r        <= 8'h00;
			w_r        <= 16'h0000;
			k_r        <= {IMM_W{1'b0}};
			f_r        <= 8'h00;
			busy_r     <= 1'b0;
			done_r     <= 1'b0;
			wrByte_r   <= 1'b0;
			wrPair_r   <= 1'b0;
			wrProd_r   <= 1'b0;
			resultLo_r <= 8'h00;
			resultHi_r <= 8'h00;
			flagsOut_r <= 8'h00;
			flagMask_r <= 8'h00;
		end else begin
			done_r   <= 1'b0;
			wrByte_r <= 1'b0;
			wrPair_r <= 1'b0;
			wrProd_r <= 1'b0;
			if (busy_r) begin
				busy_r <= 1'b0;
			end else if (start && longOp) begin
				busy_r <= 1'b1;
				op_r   <= opSel;
				a_r    <= opA;
				b_r    <= opB;
				w_r    <= wordIn;
				k_r    <= wordImm;
				f_r    <= flagsIn;
			end
			if (commit) begin
				resultLo_r <= r16[7:0];
				resultHi_r <= r16[15:8];
				// untouched flags pass through unchanged
				flagsOut_r <= (f & ~msk) | (nfl & msk);
				flagMask_r <= msk;
				done_r     <= 1'b1;
				wrByte_r   <= wB;
				wrPair_r   <= wP;
				wrProd_r   <= wM;
			end
		end
	end

endmodule

`default_nettype wire

// ### pkg/eal_map.vh
// constants of the 8-bit arithmetic and logic unit
// Overview of operation
// - add and add-with-carry: dest plus source (plus carry), 1 cycle, Z C N V H
// - word add-immediate on a 16-bit pair, 2 cycles, Z C N V S
// - subtract register or immediate from dest, 1 cycle, Z C N V H
// - subtract-with-borrow also takes carry off, 1 cycle, Z C N V H
// - word subtract-immediate on a 16-bit pair, 2 cycles, Z C N V S
// - conjunction with register or immediate, 1 cycle, only Z N V
// - inclusive or exclusive disjunction, 1 cycle, only Z N V
// - inversion is FF minus value, negation 00 minus value; negation adds H
// - mask set/clear update Z N V; fill loads FF with no flags; 1 cycle
// - increment, decrement, test and clear: 1 cycle, only Z N V
// - three 8x8 multiplies into register pair one:zero, 2 cycles, Z C
// - fractional multiplies shift product left one, 2 cycles, Z C
`ifndef EAL_MAP_VH
`define EAL_MAP_VH

// =========================================
// operation codes
`define EAL_OP_ADD    5'h00
`define EAL_OP_ADC    5'h01
`define EAL_OP_SUB    5'h02
`define EAL_OP_SBB    5'h03
`define EAL_OP_AND    5'h04
`define EAL_OP_OR     5'h05
`define EAL_OP_XOR    5'h06
`define EAL_OP_INV    5'h07
`define EAL_OP_NEGT   5'h08
`define EAL_OP_SETM   5'h09
`define EAL_OP_CLRM   5'h0A
`define EAL_OP_INC    5'h0B
`define EAL_OP_DECR   5'h0C
`define EAL_OP_TSTV   5'h0D
`define EAL_OP_ZERO   5'h0E
`define EAL_OP_FILL   5'h0F
`define EAL_OP_WADD   5'h10
`define EAL_OP_WSUB   5'h11
`define EAL_OP_MULU   5'h12
`define EAL_OP_PRDS   5'h13
`define EAL_OP_PRDSU  5'h14
`define EAL_OP_FMULU  5'h15
`define EAL_OP_FPRDS  5'h16

// =========================================
// status flag positions
`define EAL_FLG_C     0
`define EAL_FLG_Z     1
`define EAL_FLG_N     2
`define EAL_FLG_V     3
`define EAL_FLG_S     4
`define EAL_FLG_H     5

// =========================================
// flag update masks
`define EAL_MSK_ARITH 8'h2F
`define EAL_MSK_WORD  8'h1F
`define EAL_MSK_LOGIC 8'h0E
`define EAL_MSK_INV   8'h0F
`define EAL_MSK_PROD  8'h03
`define EAL_MSK_NONE  8'h00

// =========================================
// data constants and cycle counts
`define EAL_ALL_ONES  8'hFF
`define EAL_ALL_ZERO  8'h00
`define EAL_CYC_SHORT 1
`define EAL_CYC_LONG  2

`endif

// ### test/eal_alu_asserts.sv
// port checker for the arithmetic and logic unit
`timescale 1ns/100ps
`default_nettype none
module eal_alu_asserts #(
	parameter IMM_W = 6
) (
	input wire logic             clock,
	input wire logic             reset,
	input wire logic             start,
	input wire logic [4:0]       opSel,
	input wire logic [7:0]       opA,
	input wire logic [7:0]       opB,
	input wire logic [15:0]      wordIn,
	input wire logic [IMM_W-1:0] wordImm,
	input wire logic [7:0]       flagsIn,
	input wire logic [7:0]       resultLo_r,
	input wire logic [7:0]       resultHi_r,
	input wire logic             wrByte_r,
	input wire logic             wrPair_r,
	input wire logic             wrProd_r,
	input wire logic [7:0]       flagsOut_r,
	input wire logic [7:0]       flagMask_r,
	input wire logic             done_r,
	input wire logic             busy_r
);
	// =====
	// properties
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// start during busy is dropped, so only this counts as a request
	wire take = start && !busy_r;
	short_done_a: assert property (take && opSel < 5'h10 |=> done_r && wrByte_r && !busy_r)
		else $error("short op late");
	long_cycle_a: assert property (take && opSel > 5'h0F && opSel < 5'h17 |=> busy_r && !done_r ##1 done_r)
		else $error("long op timing");
	word_mask_a: assert property (take && opSel[4:1] == 4'h8 |=> ##1 wrPair_r && flagMask_r == 8'h1F)
		else $error("word op write");
	prod_mask_a: assert property (take && opSel > 5'h11 && opSel < 5'h17 |=> ##1 wrProd_r && flagMask_r == 8'h03)
		else $error("product write");
	add_sum_a: assert property (take && opSel == 5'h00 |=> resultLo_r == $past(opA) + $past(opB) && flagsOut_r[0] == ($past(opA) + $past(opB) > 9'h0FF))
		else $error("sum wrong");
	logic_mask_a: assert property (take && opSel > 5'h03 && opSel < 5'h07 |=> flagMask_r == 8'h0E && !flagsOut_r[3])
		else $error("logic flags");
	fill_quiet_a: assert property (take && opSel == 5'h0F |=> resultLo_r == 8'hFF && flagMask_r == 8'h00)
		else $error("fill wrong");
	inv_value_a: assert property (take && opSel == 5'h07 |=> resultLo_r == ~$past(opA) && flagsOut_r[0])
		else $error("inversion wrong");
	keep_flags_a: assert property (done_r && !$past(busy_r) |-> ((flagsOut_r ^ $past(flagsIn)) & ~flagMask_r) == 8'h00)
		else $error("flag kept wrongly");
	cover property (take && opSel == 5'h16);
	cover property (done_r && wrPair_r);
	cover property (start && busy_r);
endmodule
bind eal_alu eal_alu_asserts #(.IMM_W(IMM_W)) eal_alu_asserts_i (
	.clock(clock), .reset(reset), .start(start), .opSel(opSel), .opA(opA), .opB(opB),
	.wordIn(wordIn), .wordImm(wordImm), .flagsIn(flagsIn), .resultLo_r(resultLo_r),
	.resultHi_r(resultHi_r), .wrByte_r(wrByte_r), .wrPair_r(wrPair_r), .wrProd_r(wrProd_r),
	.flagsOut_r(flagsOut_r), .flagMask_r(flagMask_r), .done_r(done_r), .busy_r(busy_r)
);
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the arithmetic and logic unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
	reg         clock = 0, reset = 1, start = 0;
	reg  [4:0]  opSel = 0;
	reg  [7:0]  opA = 0, opB = 0, flagsIn = 0, eLo, eHi, eM, eF;
	reg  [15:0] wordIn = 0;
	reg  [5:0]  wordImm = 0;
	reg  [2:0]  eW;
	reg  [63:0] rnd;
	wire [7:0]  lo, hi, fo, fm;
	wire        wb, wp, wq, dn, bz;
	integer     n_mismatch = 0, checked = 0, seed = 77995, i;
	eal_alu eal_alu_i (
		.clock(clock), .reset(reset), .start(start), .opSel(opSel), .opA(opA), .opB(opB),
		.wordIn(wordIn), .wordImm(wordImm), .flagsIn(flagsIn), .resultLo_r(lo),
		.resultHi_r(hi), .wrByte_r(wb), .wrPair_r(wp), .wrProd_r(wq),
		.flagsOut_r(fo), .flagMask_r(fm), .done_r(dn), .busy_r(bz)
	);
	always #5 clock = ~clock;
	// =====
	// checking
	task check(input [15:0] seen, input [15:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", checked, n_mismatch);
			if (n_mismatch == 0 && checked > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask
	// =====
	// reference
	function void model(input [4:0] o, input [7:0] a, input [7:0] b, input [7:0] f,
		input [15:0] w, input [5:0] k);
		reg [16:0] q;
		reg [15:0] r;
		reg        cy, z, n, v, h;
		integer    sa, sb, sw, ci, s;
		begin
			case (o)
				5'h00: q = a + b;
				5'h01: q = a + b + f[0];
				5'h02: q = a - b;
				5'h03: q = a - b - f[0];
				5'h04: q = a & b;
				5'h05, 5'h09: q = a | b;
				5'h06: q = a ^ b;
				5'h07: q = {9'h001, ~a};
				5'h08: q = 17'h0 - a;
				5'h0A: q = a & ~b;
				5'h0B: q = a + 8'h01;
				5'h0C: q = a - 8'h01;
				5'h0D: q = a;
				5'h0F: q = 17'h000FF;
				5'h10: q = w + k;
				5'h11: q = w - k;
				5'h12, 5'h15: q = a * b;
				5'h13, 5'h16: q = $signed(a) * $signed(b);
				5'h14: q = $signed(a) * $signed({1'b0, b});
				default: q = 17'h0;
			endcase
			// fraction forms shift after the carry is taken from bit 15
			r = o > 5'h14 ? {q[14:0], 1'b0} : q[15:0];
			cy = o > 5'h11 ? q[15] : (o > 5'h0F ? q[16] : q[8]);
			z = (o > 5'h0F ? r == 16'h0 : r[7:0] == 8'h00) && (o != 5'h03 || f[1]);
			n = o > 5'h0F ? r[15] : r[7];
			// overflow judged on the true signed result, not on the wrapped value
			sa = $signed(a);
			sb = $signed(b);
			sw = $signed(w);
			ci = (o == 5'h01 || o == 5'h03) ? f[0] : 0;
			h = 1'b0;
			case (o)
				5'h00, 5'h01: begin
					s = sa + sb + ci;
					h = a[3:0] + b[3:0] + ci > 15;
				end
				5'h02, 5'h03: begin
					s = sa - sb - ci;
					h = a[3:0] < b[3:0] + ci;
				end
				5'h08: begin
					s = 0 - sa;
					h = a[3:0] != 4'h0;
				end
				5'h0B: s = sa + 1;
				5'h0C: s = sa - 1;
				5'h10: s = sw + k;
				5'h11: s = sw - k;
				default: s = 0;
			endcase
			v = o > 5'h0F ? (s > 32767 || s < -32768) : (s > 127 || s < -128);
			eLo = r[7:0];
			eHi = o > 5'h0F ? r[15:8] : 8'h00;
			eM = o > 5'h16 ? 8'h00 : (o < 5'h04 || o == 5'h08) ? 8'h2F : o == 5'h07 ? 8'h0F :
				o == 5'h0F ? 8'h00 : o < 5'h10 ? 8'h0E : o < 5'h12 ? 8'h1F : 8'h03;
			eF = (f & ~eM) | (eM & {2'b00, h, n ^ v, v, n, z, cy});
			eW = o < 5'h10 ? 3'b100 : o < 5'h12 ? 3'b010 : o < 5'h17 ? 3'b001 : 3'b000;
		end
	endfunction
	// =====
	// one operation, with a refused start during the busy cycle
	task run(input [4:0] o, input [7:0] a, input [7:0] b, input [7:0] f, input [15:0] w,
		input [5:0] k);
		reg long;
		begin
			long = o > 5'h0F && o < 5'h17;
			model(o, a, b, f, w, k);
			@(posedge clock);
			start <= 1'b1;
			opSel <= o;
			opA <= a;
			opB <= b;
			flagsIn <= f;
			wordIn <= w;
			wordImm <= k;
			@(posedge clock);
			start <= long;
			opSel <= 5'h0F;
			flagsIn <= ~f;
			if (long) begin
				@(negedge clock);
				check({15'h0000, bz}, 16'h0001);
				@(posedge clock);
				start <= 1'b0;
			end
			@(negedge clock);
			check({15'h0000, dn}, 16'h0001);
			check({13'h0000, wb, wp, wq}, {13'h0000, eW});
			check({8'h00, fm}, {8'h00, eM});
			check({8'h00, fo}, {8'h00, eF});
			if (o < 5'h17) check({hi, lo}, {eHi, eLo});
			@(negedge clock);
			check({15'h0000, dn}, 16'h0000);
		end
	endtask
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		run(5'h00, 8'hFF, 8'h01, 8'h00, 16'h0000, 6'h00);
		run(5'h08, 8'h80, 8'h00, 8'hFF, 16'h0000, 6'h00);
		run(5'h10, 8'h00, 8'h00, 8'hC0, 16'hFFC1, 6'h3F);
		run(5'h11, 8'h00, 8'h00, 8'h00, 16'h0000, 6'h01);
		run(5'h03, 8'h10, 8'h10, 8'h01, 16'h0000, 6'h00);
		run(5'h16, 8'h80, 8'h80, 8'h00, 16'h0000, 6'h00);
		for (i = 0; i < 400; i = i + 1) begin
			rnd = {$random(seed), $random(seed)};
			run(rnd[4:0], rnd[12:5], rnd[20:13], rnd[28:21], rnd[44:29], rnd[50:45]);
		end
		// a second reset in mid-run clears the outputs
		@(posedge clock);
		reset <= 1'b1;
		@(negedge clock);
		check({3'h0, dn, bz, wb, wp, wq, fm}, 16'h0000);
		// released again, the unit must take a fresh two-cycle op at once
		@(posedge clock);
		reset <= 1'b0;
		run(5'h12, 8'hFF, 8'hFF, 8'h00, 16'h0000, 6'h00);
		close_out;
	end
endmodule
`default_nettype wire
